/* File: src/cbg_defs.svh */
// constants of the carrier burst generator: register map, field bits, reset values
// assumes one clock that is also the carrier timer's count clock
//
// Functional notes
// - carrier counter stays stopped while the carrier run bit is clear, whatever the pulse counter run bit
// - setting the carrier run bit starts counting; carrier stays low until first match
// - low-width match: irq, invert carrier, clear counter, compare high width next
// - high-width match: irq, invert carrier, clear counter, compare low width next
// - pulse count match is synchronised into the count clock as an internal strobe
// - with remote enable 1 and slave gate set, output starts at a carrier rising edge only
// - with remote enable 1, slave gate dropping during a high pulse keeps the pin high until carrier falls
// - high-width write while running is held pending until an old-value match
// - pending high width needs three count clocks before it may transfer
// - a high match earlier than three clocks after the write keeps the old value
// - after transfer the next high phase ends at the new high width
// - clock select 07H makes the pulse counter count emitted carrier pulses
// - pulse counter raises its match when count equals pulse count compare
// - master gate copies to slave gate one clock after the synced strobe rises
// - synced strobe is internal only, used just for the gate transfer
// - remote enable 0: pin follows gate level; 1: gated carrier or low
// - period is N+M+2 count clocks with high part M+1
// - slave gate is read-only, master gate is read and write
`ifndef CBG_DEFS_SVH
`define CBG_DEFS_SVH
`define CBG_A_CTRL      3'h0
`define CBG_A_LOW       3'h1
`define CBG_A_HIGH      3'h2
`define CBG_A_PCMP      3'h3
`define CBG_A_PSEL      3'h4
`define CBG_A_TCNT      3'h5
`define CBG_A_PCNT      3'h6
`define CBG_B_CT_RUN    0
`define CBG_B_PC_RUN    1
`define CBG_B_REMOTE    2
`define CBG_B_MASTER    3
`define CBG_B_SLAVE     4
`define CBG_B_PEND      5
`define CBG_RST_8       8'h00
`define CBG_RST_SEL     3'h0
`define CBG_CNT_CLR     8'h00
`define CBG_CNT_STEP    8'h01
`define CBG_PCS_CARRIER 3'h7
`define CBG_HW_SETTLE   2'd3
`define CBG_AGE_STEP    2'd1
`define CBG_AGE_CLR     2'd0
`endif

/* File: src/cbg_pkg.sv */
// types shared by the carrier burst generator
// assumes cbg_defs.svh is compiled alongside
`default_nettype none
package cbg_pkg;
  // one register bus request, sampled on the rising clock edge
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
  } cbg_bus_s;
  // software-written control bits
  typedef struct packed {
    logic gate_master;
    logic remote_en;
    logic pc_run;
    logic ct_run;
  } cbg_ctrl_s;
endpackage
`default_nettype wire

/* File: src/cbg_top.sv */
// carrier burst generator: two-compare carrier timer, pulse counter, gated output
// assumes a single clock that is the carrier count clock, synchronous reset,
// and a register master that never issues write and read strobes together
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`include "cbg_defs.svh"
`default_nettype none
module cbg_top
  import cbg_pkg::*;
(
  input  wire logic     clk,               // count clock, 10 MHz
  input  wire logic     rst,               // synchronous reset, active high
  input  wire cbg_bus_s bus_req,           // register request
  input  wire logic     ext_event_in,      // external pulse counter source pin
  output logic [7:0]    rdata,             // read data, cycle after read strobe
  output logic          carrier_out_pin,   // modulated carrier output
  output logic          carrier_match_irq, // one-cycle pulse per width match
  output logic          pulse_count_match  // one-cycle pulse on pulse counter match
);

  function automatic logic f_rise(input logic now_v, input logic prev_v);
    f_rise = now_v & ~prev_v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state
  cbg_ctrl_s  ctrl_r;
  logic       gate_slave_r;
  logic [7:0] low_cmp_r;
  logic [7:0] high_cmp_r;
  logic [7:0] pend_val_r;
  logic       pend_vld_r;
  logic [1:0] pend_age_r;
  logic [7:0] pcmp_r;
  logic [2:0] psel_r;
  logic [7:0] cnt_r;
  logic       phase_r;
  logic       carrier_r;
  logic       emit_r;
  logic       out_r;
  logic       out_d_r;
  logic [7:0] pcnt_r;
  logic       pmatch_r;
  logic       sync_r;
  logic       sync_d_r;
  logic       ext_s1_r;
  logic       ext_s2_r;
  logic       ext_s3_r;
  logic       irq_r;
  logic [7:0] rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // register decode
  wire wr_ctrl = bus_req.we && (bus_req.addr == `CBG_A_CTRL);
  wire wr_low  = bus_req.we && (bus_req.addr == `CBG_A_LOW);
  wire wr_high = bus_req.we && (bus_req.addr == `CBG_A_HIGH);
  wire wr_pcmp = bus_req.we && (bus_req.addr == `CBG_A_PCMP);
  wire wr_psel = bus_req.we && (bus_req.addr == `CBG_A_PSEL);
  wire running = ctrl_r.ct_run;

  // control byte as read back; slave and pending are status only
  wire [7:0] ctrl_rd = {2'b00, pend_vld_r, gate_slave_r, ctrl_r.gate_master,
                        ctrl_r.remote_en, ctrl_r.pc_run, ctrl_r.ct_run};
  wire cbg_ctrl_s ctrl_wr = '{gate_master: bus_req.wdata[`CBG_B_MASTER],
                              remote_en:   bus_req.wdata[`CBG_B_REMOTE],
                              pc_run:      bus_req.wdata[`CBG_B_PC_RUN],
                              ct_run:      bus_req.wdata[`CBG_B_CT_RUN]};

  // read mux; address 7 is unmapped and reads zero
  wire [7:0] rd_mux =
    (bus_req.addr == `CBG_A_CTRL) ? ctrl_rd :
    (bus_req.addr == `CBG_A_LOW)  ? low_cmp_r :
    (bus_req.addr == `CBG_A_HIGH) ? high_cmp_r :
    (bus_req.addr == `CBG_A_PCMP) ? pcmp_r :
    (bus_req.addr == `CBG_A_PSEL) ? {5'b00000, psel_r} :
    (bus_req.addr == `CBG_A_TCNT) ? cnt_r :
    (bus_req.addr == `CBG_A_PCNT) ? pcnt_r : `CBG_RST_8;

  // control bits and pulse counter setup
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl_r <= '0;
      pcmp_r <= `CBG_RST_8;
      psel_r <= `CBG_RST_SEL;
      rdata_r <= `CBG_RST_8;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_r <= ctrl_wr;
      if (wr_pcmp)
        pcmp_r <= bus_req.wdata;  // burst length minus one
      if (wr_psel)
        psel_r <= bus_req.wdata[2:0];
      rdata_r <= bus_req.re ? rd_mux : `CBG_RST_8;
    end
  end

  // low width may only change while stopped; a running write is dropped
  always_ff @(posedge clk)
  begin
    if (rst)
      low_cmp_r <= `CBG_RST_8;
    else if (wr_low && !running)
      low_cmp_r <= bus_req.wdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // carrier timer
  wire low_hit  = running && !phase_r && (cnt_r == low_cmp_r);
  wire high_hit = running && phase_r && (cnt_r == high_cmp_r);
  wire any_hit  = low_hit || high_hit;
  wire pend_ok  = pend_vld_r && (pend_age_r >= `CBG_HW_SETTLE);
  wire take_pend = high_hit && pend_ok;

  wire [7:0] cnt_nxt = !running ? `CBG_CNT_CLR :
                       any_hit ? `CBG_CNT_CLR :
                       cnt_r + `CBG_CNT_STEP;
  wire phase_nxt   = running && (phase_r ^ any_hit);
  wire carrier_nxt = running && (carrier_r ^ any_hit);

  // counter, compare select and carrier level
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_r <= `CBG_CNT_CLR;
      phase_r <= 1'b0;
      carrier_r <= 1'b0;
      irq_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      phase_r <= phase_nxt;
      carrier_r <= carrier_nxt;
      irq_r <= any_hit;
    end
  end

  // high width: direct load while stopped, pending while running
  // a fresh write restarts the settle count so a half-settled value never lands
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      high_cmp_r <= `CBG_RST_8;
      pend_val_r <= `CBG_RST_8;
      pend_vld_r <= 1'b0;
      pend_age_r <= `CBG_AGE_CLR;
    end
    else
    begin
      if (take_pend)
        high_cmp_r <= pend_val_r;
      else if (wr_high && !running)
        high_cmp_r <= bus_req.wdata;
      if (wr_high && running)
      begin
        pend_val_r <= bus_req.wdata;
        pend_vld_r <= 1'b1;
        pend_age_r <= `CBG_AGE_CLR;
      end
      else
      begin
        if (take_pend || !running)
          pend_vld_r <= 1'b0;
        if (pend_vld_r && !pend_ok)
          pend_age_r <= pend_age_r + `CBG_AGE_STEP;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // gated output
  wire car_rise = f_rise(carrier_nxt, carrier_r);
  // emit starts only on a carrier rise; with the gate shut it only finishes the pulse in flight
  wire emit_nxt = !ctrl_r.remote_en ? 1'b0 :
                  gate_slave_r ? (emit_r || car_rise) :
                  (emit_r && carrier_r && carrier_nxt);
  wire out_nxt = ctrl_r.remote_en ? (emit_nxt && carrier_nxt)
                                  : gate_slave_r;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      emit_r <= 1'b0;
      out_r <= 1'b0;
      out_d_r <= 1'b0;
    end
    else
    begin
      emit_r <= emit_nxt;
      out_r <= out_nxt;
      out_d_r <= out_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pulse counter; the pin source is synchronised, s1 feeds only s2
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
    end
    else
    begin
      ext_s1_r <= ext_event_in;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end

  wire pc_evt = (psel_r == `CBG_PCS_CARRIER) ? f_rise(out_r, out_d_r)
                                             : f_rise(ext_s2_r, ext_s3_r);
  wire pc_hit = ctrl_r.pc_run && pc_evt && (pcnt_r == pcmp_r);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pcnt_r <= `CBG_CNT_CLR;
      pmatch_r <= 1'b0;
    end
    else
    begin
      if (!ctrl_r.pc_run || pc_hit)
        pcnt_r <= `CBG_CNT_CLR;
      else if (pc_evt)
        pcnt_r <= pcnt_r + `CBG_CNT_STEP;
      pmatch_r <= pc_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // match sync and gate transfer; the strobe drives no irq
  // the copy lands one count clock after the synced strobe rises
  wire sync_rise = f_rise(sync_r, sync_d_r);
  wire slave_nxt = sync_rise ? ctrl_r.gate_master : gate_slave_r;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync_r <= 1'b0;
      sync_d_r <= 1'b0;
      gate_slave_r <= 1'b0;
    end
    else
    begin
      sync_r <= pmatch_r;
      sync_d_r <= sync_r;
      gate_slave_r <= slave_nxt;
    end
  end

  // outputs
  assign rdata = rdata_r;
  assign carrier_out_pin = out_r;
  assign carrier_match_irq = irq_r;
  assign pulse_count_match = pmatch_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_stop_hold;
    @(posedge clk) disable iff (rst)
    !running |=> (cnt_r == `CBG_CNT_CLR) && !carrier_r && !phase_r;
  endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("counter not held while stopped");

  property p_low_phase_low;
    @(posedge clk) disable iff (rst)
    !carrier_r && !(running && !phase_r && (cnt_r == low_cmp_r)) |=> !carrier_r;
  endproperty
  a_low_phase_low: assert property (p_low_phase_low)
    else $error("carrier rose without a low width match");

  property p_low_match;
    @(posedge clk) disable iff (rst)
    running && !phase_r && (cnt_r == low_cmp_r) && ctrl_r.ct_run
    |=> (cnt_r == `CBG_CNT_CLR) && carrier_match_irq && phase_r && carrier_r;
  endproperty
  a_low_match: assert property (p_low_match)
    else $error("low width match mishandled");

  property p_high_match;
    @(posedge clk) disable iff (rst)
    running && phase_r && (cnt_r == high_cmp_r)
    |=> (cnt_r == `CBG_CNT_CLR) && carrier_match_irq && !phase_r && !carrier_r;
  endproperty
  a_high_match: assert property (p_high_match)
    else $error("high width match mishandled");

  property p_sync;
    @(posedge clk) disable iff (rst)
    pulse_count_match |=> sync_r;
  endproperty
  a_sync: assert property (p_sync)
    else $error("match not synchronised");

  property p_xfer;
    @(posedge clk) disable iff (rst)
    (sync_r && !sync_d_r) |=> (gate_slave_r == $past(ctrl_r.gate_master));
  endproperty
  a_xfer: assert property (p_xfer)
    else $error("gate transfer mistimed");

  property p_no_midpulse;
    @(posedge clk) disable iff (rst)
    $rose(out_r) && $past(ctrl_r.remote_en) && ctrl_r.remote_en
    |-> ($past(carrier_r) == 1'b0);
  endproperty
  a_no_midpulse: assert property (p_no_midpulse)
    else $error("output started mid pulse");

  property p_hold_high;
    @(posedge clk) disable iff (rst)
    (ctrl_r.remote_en && out_r) ##1 (ctrl_r.remote_en && carrier_r)
    |-> out_r;
  endproperty
  a_hold_high: assert property (p_hold_high)
    else $error("high pulse cut short");

  property p_early_keep;
    @(posedge clk) disable iff (rst)
    high_hit && pend_vld_r && (pend_age_r < `CBG_HW_SETTLE)
    |=> $stable(high_cmp_r);
  endproperty
  a_early_keep: assert property (p_early_keep)
    else $error("pending width taken too early");

  property p_take;
    @(posedge clk) disable iff (rst)
    high_hit && pend_ok |=> (high_cmp_r == $past(pend_val_r));
  endproperty
  a_take: assert property (p_take)
    else $error("pending width not taken");

  property p_pc_match;
    @(posedge clk) disable iff (rst)
    ctrl_r.pc_run && pc_evt && (pcnt_r == pcmp_r) |=> pulse_count_match;
  endproperty
  a_pc_match: assert property (p_pc_match)
    else $error("pulse count match missed");

  property p_gate_level;
    @(posedge clk) disable iff (rst)
    !ctrl_r.remote_en |=> (out_r == $past(gate_slave_r));
  endproperty
  a_gate_level: assert property (p_gate_level)
    else $error("pin does not follow gate");

  property p_gate_shut;
    @(posedge clk) disable iff (rst)
    ctrl_r.remote_en && !gate_slave_r && !out_r |=> !out_r;
  endproperty
  a_gate_shut: assert property (p_gate_shut)
    else $error("pulse started with gate shut");

endmodule
`default_nettype wire

/* File: sim/cbg_load_model.sv */
// external load on the carrier output pin: counts pulses and clipped pulses
// assumes the pin is a registered level that changes just after the count clock edge
`default_nettype none
module cbg_load_model #(
  parameter int HI_W = 3 // expected high width in count clocks
) (
  input  wire logic clk,    // count clock
  input  wire logic rst,    // synchronous reset, active high
  input  wire logic pin,    // carrier output pin
  output var  int   pulses, // rising edges seen
  output var  int   odd     // high pulses of any other width
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prev;
  int   width;
  ////////////////////////////////////////////////////////////////////////////
  // a pulse of the wrong width means the gate cut the carrier mid-pulse
  always @(posedge clk)
  begin
    if (rst)
    begin
      prev <= 1'b0;
      width <= 0;
      pulses <= 0;
      odd <= 0;
    end
    else
    begin
      if (pin && !prev)
        pulses <= pulses + 1;
      if (pin)
        width <= width + 1;
      else
        width <= 0;
      if (!pin && prev && width != HI_W)
        odd <= odd + 1;
      prev <= pin;
    end
  end
endmodule
`default_nettype wire

/* File: sim/carrier_burst_generator_tb.sv */
// testbench of the carrier burst generator: registers, carrier timing, burst gating
// assumes cbg_top, cbg_pkg and cbg_defs.svh; one 10 MHz count clock
`include "cbg_defs.svh"
`default_nettype none
module carrier_burst_generator_tb
  import cbg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk;
  logic       rst;
  cbg_bus_s   bus_req;
  logic       ext_event_in;
  logic [7:0] rdata;
  logic       carrier_out_pin;
  logic       carrier_match_irq;
  logic       pulse_count_match;
  int         err_count;
  int         n_tests;
  int         pulses;
  int         odd;
  ////////////////////////////////////////////////////////////////////////////
  // design and the load on its pin
  cbg_top u_cbg_top (
    .clk(clk),
    .rst(rst),
    .bus_req(bus_req),
    .ext_event_in(ext_event_in),
    .rdata(rdata),
    .carrier_out_pin(carrier_out_pin),
    .carrier_match_irq(carrier_match_irq),
    .pulse_count_match(pulse_count_match)
  );
  cbg_load_model #(.HI_W(3)) u_cbg_load_model (
    .clk(clk),
    .rst(rst),
    .pin(carrier_out_pin),
    .pulses(pulses),
    .odd(odd)
  );
  // 100 ns count clock
  initial
    clk = 1'b0;
  always #50 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (err_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // bus cycles: strobe for one cycle, read data judged in the cycle after
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge clk);
    bus_req <= '0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
    @(posedge clk);
    bus_req <= '0;
    #1;
    chk(rdata, exp);
  endtask
  // cycles up to the next match pulse, bounded so a dead timer cannot hang
  task automatic gap(output int n);
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (carrier_match_irq !== 1'b1 && n < 600);
  endtask
  task automatic wait_pcm();
    int k;
    k = 0;
    while (pulse_count_match !== 1'b1 && k < 200)
    begin
      @(negedge clk);
      k++;
    end
    chk({7'h00, k < 200}, 8'h01);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    for (int a = 0; a < 8; a++)
      rd(3'(a), 8'h00);
    wr(`CBG_A_CTRL, 8'h30);
    wr(3'h7, 8'h5a);
    rd(`CBG_A_CTRL, 8'h00);
    rd(3'h7, 8'h00);
  endtask
  // widths N=1, M=2, then a late high-width update while running
  task automatic t_carrier();
    int n;
    wr(`CBG_A_LOW, 8'h01);
    wr(`CBG_A_HIGH, 8'h02);
    wr(`CBG_A_CTRL, 8'h01);
    gap(n);
    chk(8'(n), 8'h03);
    gap(n);
    chk(8'(n), 8'h03);
    gap(n);
    chk(8'(n), 8'h02);
    wr(`CBG_A_HIGH, 8'h05);
    rd(`CBG_A_HIGH, 8'h02);
    gap(n);
    gap(n);
    chk(8'(n), 8'h03);
    gap(n);
    chk(8'(n), 8'h02);
    gap(n);
    chk(8'(n), 8'h06);
    rd(`CBG_A_HIGH, 8'h05);
    wr(`CBG_A_CTRL, 8'h00);
    repeat (2) @(negedge clk);
    repeat (12)
    begin
      @(negedge clk);
      chk({7'h00, carrier_match_irq}, 8'h00);
    end
    rd(`CBG_A_TCNT, 8'h00);
  endtask
  // gate opened by one external event, then a burst of three carrier pulses
  task automatic t_burst();
    int p0;
    int o0;
    wr(`CBG_A_HIGH, 8'h02);
    wr(`CBG_A_PSEL, 8'h00);
    wr(`CBG_A_PCMP, 8'h00);
    wr(`CBG_A_CTRL, 8'h0a);
    @(posedge clk);
    ext_event_in <= 1'b1;
    wait_pcm();
    repeat (2) @(negedge clk);
    chk({7'h00, carrier_out_pin}, 8'h00);
    @(negedge clk);
    chk({7'h00, carrier_out_pin}, 8'h01);
    rd(`CBG_A_CTRL, 8'h1a);
    @(posedge clk);
    ext_event_in <= 1'b0;
    wr(`CBG_A_CTRL, 8'h06);
    repeat (3) @(negedge clk);
    chk({7'h00, carrier_out_pin}, 8'h00);
    p0 = pulses;
    o0 = odd;
    wr(`CBG_A_PSEL, 8'h07);
    wr(`CBG_A_PCMP, 8'h02);
    wr(`CBG_A_CTRL, 8'h07);
    repeat (60) @(negedge clk);
    chk(8'(pulses - p0), 8'h03);
    chk(8'(odd - o0), 8'h00);
    rd(`CBG_A_CTRL, 8'h07);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    rst = 1'b1;
    bus_req = '0;
    ext_event_in = 1'b0;
    err_count = 0;
    n_tests = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_carrier();
    t_burst();
    complete_run();
  end
  // watchdog: the tests need well under a thousand cycles
  initial
  begin
    #(100 * 5000);
    err_count++;
    complete_run();
  end
endmodule
`default_nettype wire
